// ---- design/rtcat_alarm_timer.sv ----
// Alarm comparison and 8-bit countdown timer with register port and interrupt pin
`timescale 1ns/1ps
`include "rtcat_cfg.svh"
module rtcat_alarm_timer (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       osc_in,
  input  wire logic       corr_add,
  input  wire logic       corr_omit,
  input  wire logic       time_tick,
  input  wire logic [6:0] cur_sec,
  input  wire logic [6:0] cur_min,
  input  wire logic [5:0] cur_hour,
  input  wire logic [5:0] cur_day,
  input  wire logic [2:0] cur_wday,
  input  wire logic [4:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  output logic            irq_n
);
  logic [7:0] sec_alm_r;
  logic [7:0] min_alm_r;
  logic [7:0] hour_alm_r;
  logic [7:0] day_alm_r;
  logic [7:0] wday_alm_r;
  logic [7:0] reload_r;
  logic [7:0] ctrl_r;
  logic [7:0] cnt_r;
  logic [7:0] pw_cnt_r;
  logic [7:0] rdata_r;
  logic       aie_r;
  logic       af_r;
  logic       tf_r;
  logic       match_prev_r;
  logic       pulse_on_r;
  logic       irq_n_r;
  logic       af_nxt;
  logic       tf_nxt;
  logic       pulse_nxt;
  logic       aie_nxt;
  logic [7:0] ctrl_nxt;
  logic       match;
  logic       af_set;
  logic       tf_set;
  logic       src_tick;
  logic       run;
  logic       countdown_irq_on;
  logic       tp;
  logic [4:0] alm_on;
  logic [4:0] alm_eq;
  rtcat_pkg::rtcat_src_e src;
  rtcat_pkg::rtcat_tmr_e state_r;

  rtcat_tick_if tk ();

  rtcat_prescaler u_pre (
    .clk       (clk),
    .nrst      (nrst),
    .osc_in    (osc_in),
    .corr_add  (corr_add),
    .corr_omit (corr_omit),
    .tk        (tk)
  );

  function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
    return a == o;
  endfunction

  function automatic logic [7:0] pw_len(input rtcat_pkg::rtcat_src_e s,
                                        input logic [7:0] t);
    logic one;
    one = (t == 8'h01);
    unique case (s)
      rtcat_pkg::RTCAT_SRC_4K: pw_len = one ? `RTCAT_PW_4K_T1 : `RTCAT_PW_4K;
      rtcat_pkg::RTCAT_SRC_64: pw_len = one ? `RTCAT_PW_64_T1 : `RTCAT_PW_64;
      rtcat_pkg::RTCAT_SRC_1,
      rtcat_pkg::RTCAT_SRC_60: pw_len = `RTCAT_PW_SLOW;
    endcase
  endfunction

  assign src = rtcat_pkg::rtcat_src_e'(ctrl_r[`RTCAT_B_SRC_HI:`RTCAT_B_SRC_LO]);
  assign run = ctrl_r[`RTCAT_B_RUN];
  assign countdown_irq_on = ctrl_r[`RTCAT_B_TIE];
  assign tp  = ctrl_r[`RTCAT_B_TP];

  ////////////////////////////////////////////////////////////////////////////
  // Alarm registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sec_alm_r  <= `RTCAT_RST_ALARM;
      min_alm_r  <= `RTCAT_RST_ALARM;
      hour_alm_r <= `RTCAT_RST_ALARM;
      day_alm_r  <= `RTCAT_RST_ALARM;
      wday_alm_r <= `RTCAT_RST_ALARM;
    end else if (wr_stb) begin
      if (hit(addr, `RTCAT_A_SEC)) begin
        sec_alm_r <= wdata & `RTCAT_WM_SEC;
      end
      if (hit(addr, `RTCAT_A_MIN)) begin
        min_alm_r <= wdata & `RTCAT_WM_SEC;
      end
      if (hit(addr, `RTCAT_A_HOUR)) begin
        hour_alm_r <= wdata & `RTCAT_WM_HOUR;
      end
      if (hit(addr, `RTCAT_A_DAY)) begin
        day_alm_r <= wdata & `RTCAT_WM_DAY;
      end
      if (hit(addr, `RTCAT_A_WDAY)) begin
        wday_alm_r <= wdata & `RTCAT_WM_WDAY;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm comparison
  always_comb begin
    alm_on = ~{sec_alm_r[`RTCAT_B_OFF], min_alm_r[`RTCAT_B_OFF], hour_alm_r[`RTCAT_B_OFF],
               day_alm_r[`RTCAT_B_OFF], wday_alm_r[`RTCAT_B_OFF]};
    alm_eq = {sec_alm_r[6:0] == cur_sec, min_alm_r[6:0] == cur_min,
              hour_alm_r[5:0] == cur_hour, day_alm_r[5:0] == cur_day,
              wday_alm_r[2:0] == cur_wday};
    // With every field off nothing can match, so the flag never fires
    match = (|alm_on) & (&(alm_eq | ~alm_on));
  end

  // Only the tick that enters a match sets the flag, so clearing it inside
  // a still-matching window does not re-raise it
  assign af_set = time_tick & match & ~match_prev_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      match_prev_r <= 1'b0;
    end else if (time_tick) begin
      match_prev_r <= match;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag register: writing 0 to a flag clears it, a set in the same cycle wins
  always_comb begin
    af_nxt  = af_r;
    tf_nxt  = tf_r;
    aie_nxt = aie_r;
    if (wr_stb && hit(addr, `RTCAT_A_FLAGS)) begin
      aie_nxt = wdata[`RTCAT_B_AIE];
      af_nxt = af_r & wdata[`RTCAT_B_AF];
      tf_nxt = tf_r & wdata[`RTCAT_B_TF];
    end
    if (af_set) begin
      af_nxt = 1'b1;
    end
    if (tf_set) begin
      tf_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      af_r  <= 1'b0;
      tf_r  <= 1'b0;
      aie_r <= 1'b0;
    end else begin
      af_r <= af_nxt;
      tf_r  <= tf_nxt;
      aie_r <= aie_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer configuration
  assign ctrl_nxt = (wr_stb && hit(addr, `RTCAT_A_CTRL)) ? (wdata & `RTCAT_WM_CTRL) : ctrl_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reload_r <= `RTCAT_RST_VAL;
      ctrl_r   <= `RTCAT_RST_CTRL;
    end else if (wr_stb) begin
      if (hit(addr, `RTCAT_A_VAL)) begin
        reload_r <= wdata;
      end
      ctrl_r <= ctrl_nxt;
    end
  end

  always_comb begin
    unique case (src)
      rtcat_pkg::RTCAT_SRC_4K: src_tick = tk.t4096;
      rtcat_pkg::RTCAT_SRC_64: src_tick = tk.t64;
      rtcat_pkg::RTCAT_SRC_1:  src_tick = tk.t1;
      rtcat_pkg::RTCAT_SRC_60: src_tick = tk.t1_60;
    endcase
  end

  assign tf_set = (state_r == rtcat_pkg::RTCAT_T_CNT) & run & (reload_r != 8'h00) &
                  src_tick & (cnt_r <= 8'h01);

  ////////////////////////////////////////////////////////////////////////////
  // Timer sequencing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= rtcat_pkg::RTCAT_T_IDLE;
    end else begin
      unique case (state_r)
        rtcat_pkg::RTCAT_T_IDLE: begin
          if (run && reload_r != 8'h00) begin
            state_r <= rtcat_pkg::RTCAT_T_LOAD;
          end
        end
        rtcat_pkg::RTCAT_T_LOAD: begin
          // Fast sources spend one tick aligning, so the first period is T to T+1
          if (src_tick || src[1]) begin
            state_r <= rtcat_pkg::RTCAT_T_CNT;
          end
        end
        rtcat_pkg::RTCAT_T_CNT: begin
          if (!run || reload_r == 8'h00) begin
            state_r <= rtcat_pkg::RTCAT_T_IDLE;
          end
        end
        default: begin
          state_r <= rtcat_pkg::RTCAT_T_IDLE;
        end
      endcase
    end
  end

  // Prescaler runs free, so the first tick after enabling lands anywhere
  // within one source period: that is the first-period uncertainty
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= `RTCAT_RST_VAL;
    end else if (wr_stb && hit(addr, `RTCAT_A_VAL)) begin
      cnt_r <= wdata;
    end else if (state_r == rtcat_pkg::RTCAT_T_LOAD) begin
      cnt_r <= reload_r;
    end else if (tf_set) begin
      cnt_r <= reload_r;
    end else if (state_r == rtcat_pkg::RTCAT_T_CNT && run && src_tick) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pulse timed on 8192 Hz ticks
  always_comb begin
    pulse_nxt = pulse_on_r;
    if (tf_set) begin
      pulse_nxt = 1'b1;
    end else if (pulse_on_r && tk.t8192 && pw_cnt_r <= 8'h01) begin
      pulse_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulse_on_r <= 1'b0;
      pw_cnt_r   <= 8'h00;
    end else begin
      pulse_on_r <= pulse_nxt;
      if (tf_set) begin
        pw_cnt_r <= pw_len(src, reload_r);
      end else if (pulse_on_r && tk.t8192) begin
        pw_cnt_r <= pw_cnt_r - 8'h01;
      end
    end
  end

  // Built from next-state values so flag and pin move on the same edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_n_r <= 1'b1;
    end else begin
      irq_n_r <= ~((aie_nxt & af_nxt) |
                   (ctrl_nxt[`RTCAT_B_TIE] &
                    (ctrl_nxt[`RTCAT_B_TP] ? pulse_nxt : tf_nxt)));
    end
  end

  assign irq_n = irq_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
    end else if (rd_stb) begin
      unique case (addr)
        `RTCAT_A_FLAGS: rdata_r <= {aie_r, af_r, 2'h0, tf_r, 3'h0};
        `RTCAT_A_SEC:   rdata_r <= sec_alm_r;
        `RTCAT_A_MIN:   rdata_r <= min_alm_r;
        `RTCAT_A_HOUR:  rdata_r <= hour_alm_r;
        `RTCAT_A_DAY:   rdata_r <= day_alm_r;
        `RTCAT_A_WDAY:  rdata_r <= wday_alm_r;
        `RTCAT_A_VAL:   rdata_r <= cnt_r;
        `RTCAT_A_CTRL:  rdata_r <= ctrl_r;
        default:        rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_val_write;
    wr_stb && hit(addr, `RTCAT_A_VAL) |=> cnt_r == $past(wdata) && reload_r == $past(wdata);
  endproperty
  a_val_write: assert property (p_val_write) else $error("reload write not applied");

  property p_zero_stop;
    reload_r == 8'h00 && !wr_stb |=> cnt_r == $past(cnt_r) && !tf_set;
  endproperty
  a_zero_stop: assert property (p_zero_stop) else $error("timer ran with zero reload");

  property p_done_irq;
    $rose(tf_r) && countdown_irq_on && !tp |-> !irq_n;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done flag without interrupt");

  property p_alarm_irq;
    aie_r && af_r |-> !irq_n;
  endproperty
  a_alarm_irq: assert property (p_alarm_irq) else $error("alarm flag not on pin");

  property p_all_off;
    (&(~alm_on)) |-> !match;
  endproperty
  a_all_off: assert property (p_all_off) else $error("match with every field off");

  property p_af_sticky;
    af_r && !(wr_stb && hit(addr, `RTCAT_A_FLAGS)) |=> af_r;
  endproperty
  a_af_sticky: assert property (p_af_sticky) else $error("alarm flag dropped");

  property p_irq_quiet;
    !countdown_irq_on && !(aie_r && af_r) |-> irq_n;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt while gated");

  property p_live_read;
    rd_stb && hit(addr, `RTCAT_A_VAL) |=> rdata == $past(cnt_r);
  endproperty
  a_live_read: assert property (p_live_read) else $error("count read wrong");

  property p_pw_short;
    tf_set && src == rtcat_pkg::RTCAT_SRC_4K && reload_r == 8'h01 |=>
      pulse_on_r && pw_cnt_r == `RTCAT_PW_4K_T1;
  endproperty
  a_pw_short: assert property (p_pw_short) else $error("short pulse width wrong");

  c_alarm: cover property (af_set && aie_r);
  c_period: cover property (tf_set && run);
  c_pulse_end: cover property ($fell(pulse_on_r) && tp && countdown_irq_on);
endmodule

// ---- design/rtcat_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the alarm/timer block
`ifndef RTCAT_CFG_SVH
`define RTCAT_CFG_SVH

`define RTCAT_A_FLAGS    5'h01
`define RTCAT_A_SEC      5'h0B
`define RTCAT_A_MIN      5'h0C
`define RTCAT_A_HOUR     5'h0D
`define RTCAT_A_DAY      5'h0E
`define RTCAT_A_WDAY     5'h0F
`define RTCAT_A_VAL      5'h10
`define RTCAT_A_CTRL     5'h11

`define RTCAT_RST_ALARM  8'h80
`define RTCAT_RST_VAL    8'h00
`define RTCAT_RST_CTRL   8'h18

// Writable bits per register; the rest read as zero
`define RTCAT_WM_SEC     8'hFF
`define RTCAT_WM_HOUR    8'hBF
`define RTCAT_WM_DAY     8'hBF
`define RTCAT_WM_WDAY    8'h87
`define RTCAT_WM_CTRL    8'h1F

`define RTCAT_B_OFF      7
`define RTCAT_B_SRC_HI   4
`define RTCAT_B_SRC_LO   3
`define RTCAT_B_RUN      2
`define RTCAT_B_TIE      1
`define RTCAT_B_TP       0
`define RTCAT_B_AIE      7
`define RTCAT_B_AF       6
`define RTCAT_B_TF       3

// Interrupt pulse widths in 8192 Hz ticks
`define RTCAT_PW_4K_T1   8'h01
`define RTCAT_PW_4K      8'h02
`define RTCAT_PW_64_T1   8'h40
`define RTCAT_PW_64      8'h80
`define RTCAT_PW_SLOW    8'h80

// Divider taps on the oscillator count
`define RTCAT_TAP_8192   9'h003
`define RTCAT_TAP_4096   9'h007
`define RTCAT_TAP_64     9'h1FF
`define RTCAT_LAST_SEC   6'h3B

`endif

// ---- design/rtcat_pkg.sv ----
// Types shared by the alarm/timer block
package rtcat_pkg;
  typedef enum logic [1:0] {
    RTCAT_SRC_4K = 2'h0,
    RTCAT_SRC_64 = 2'h1,
    RTCAT_SRC_1  = 2'h2,
    RTCAT_SRC_60 = 2'h3
  } rtcat_src_e;

  typedef enum logic [1:0] {
    RTCAT_T_IDLE = 2'h0,
    RTCAT_T_LOAD = 2'h1,
    RTCAT_T_CNT  = 2'h3
  } rtcat_tmr_e;
endpackage

// ---- design/rtcat_prescaler.sv ----
// Divides the synchronised 32.768 kHz oscillator into timer source ticks
`timescale 1ns/1ps
`include "rtcat_cfg.svh"
module rtcat_prescaler (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic osc_in,
  input  wire logic corr_add,
  input  wire logic corr_omit,
  rtcat_tick_if.src tk
);
  logic [2:0] osc_sync_r;
  logic [8:0] low_r;
  logic [5:0] high_r;
  logic [5:0] sec_r;
  logic       osc_rise;
  logic       step_64;

  function automatic logic tap(input logic [8:0] v, input logic [8:0] m);
    return (v & m) == m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_sync_r <= 3'h0;
    end else begin
      osc_sync_r <= {osc_sync_r[1:0], osc_in};
    end
  end

  assign osc_rise = osc_sync_r[1] & ~osc_sync_r[2];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_r <= 9'h000;
    end else if (osc_rise) begin
      low_r <= low_r + 9'h001;
    end
  end

  assign tk.t8192 = osc_rise & tap(low_r, `RTCAT_TAP_8192);
  assign tk.t4096 = osc_rise & tap(low_r, `RTCAT_TAP_4096);
  assign tk.t64   = osc_rise & tap(low_r, `RTCAT_TAP_64);

  // Correction sits above 64 Hz so only the 1 Hz and 1/60 Hz sources move
  assign step_64 = (tk.t64 & ~corr_omit) | corr_add;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      high_r <= 6'h00;
    end else if (step_64) begin
      high_r <= high_r + 6'h01;
    end
  end

  assign tk.t1 = step_64 & (high_r == 6'h3F);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sec_r <= 6'h00;
    end else if (tk.t1) begin
      sec_r <= (sec_r == `RTCAT_LAST_SEC) ? 6'h00 : sec_r + 6'h01;
    end
  end

  assign tk.t1_60 = tk.t1 & (sec_r == `RTCAT_LAST_SEC);
endmodule

// ---- design/rtcat_tick_if.sv ----
// Source-clock tick pulses from the prescaler to the timer logic
`timescale 1ns/1ps
interface rtcat_tick_if;
  logic t8192;
  logic t4096;
  logic t64;
  logic t1;
  logic t1_60;
  modport src (output t8192, output t4096, output t64, output t1, output t1_60);
  modport dst (input t8192, input t4096, input t64, input t1, input t1_60);
endinterface

// ---- testbench/rtcat_alarm_timer_tb.sv ----
// Self-checking bench for the alarm and countdown timer block
`timescale 1ns/1ps
`include "rtcat_cfg.svh"
module rtcat_alarm_timer_tb;
  logic       clk;
  logic       nrst;
  logic       osc_in;
  logic       time_tick;
  logic [6:0] cur_sec;
  logic [5:0] cur_day;
  logic [2:0] cur_wday;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] rdata;
  logic       irq_n;
  logic [7:0] rv;
  int         errors;
  int         n_tests;
  int         n;

  rtcat_alarm_timer dut (
    .clk       (clk),
    .nrst      (nrst),
    .osc_in    (osc_in),
    .corr_add  (1'b0),
    .corr_omit (1'b0),
    .time_tick (time_tick),
    .cur_sec   (cur_sec),
    .cur_min   (7'h00),
    .cur_hour  (6'h00),
    .cur_day   (cur_day),
    .cur_wday  (cur_wday),
    .addr      (addr),
    .wdata     (wdata),
    .wr_stb    (wr_stb),
    .rd_stb    (rd_stb),
    .rdata     (rdata),
    .irq_n     (irq_n)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Fast oscillator, 8 clocks a period, off the clock edges to keep timing exact
  initial begin
    osc_in = 1'b0;
    #1;
    forever #16 osc_in = ~osc_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic rng(input int v, input int lo, input int hi, input string m);
    n_tests++;
    if (v < lo || v > hi) begin
      errors++;
      $display("BAD %0t %s %0d not in %0d..%0d", $time, m, v, lo, hi);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [7:0] e, input string m);
    logic [7:0] d;
    rd(a, d);
    chk(d, e, m);
  endtask

  task automatic wait_irq(input logic e, input int lim, output int c);
    c = 0;
    while (irq_n !== e) begin
      @(posedge clk);
      #1;
      c++;
      if (c >= lim) begin
        rng(c, 0, lim - 1, "irq wait");
        results();
      end
    end
  endtask

  // Count cycles in which the pin left its idle high level
  task automatic hold(input int cyc, input string m);
    int k;
    k = 0;
    repeat (cyc) begin
      @(posedge clk);
      #1;
      if (irq_n !== 1'b1) k++;
    end
    rng(k, 0, 0, m);
  endtask

  // Poll the live count until it shows v; the read is bounded
  task automatic sync_cnt(input logic [7:0] v);
    logic [7:0] d;
    int         k;
    k = 0;
    d = 8'h00;
    while (d !== v && k < 200) begin
      rd(`RTCAT_A_VAL, d);
      k++;
    end
    chk(d, v, "live count");
    if (d !== v) results();
  endtask

  task automatic tick(input logic [5:0] d, input logic [2:0] w);
    @(posedge clk);
    cur_day   <= d;
    cur_wday  <= w;
    time_tick <= 1'b1;
    @(posedge clk);
    time_tick <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // First fall only synchronises: the first period after a change is uncertain
  task automatic pulse(input int plo, input int phi, input int wlo, input int whi);
    int c;
    int w;
    wait_irq(1'b1, 20000, c);
    wait_irq(1'b0, 20000, c);
    wait_irq(1'b1, 20000, w);
    wait_irq(1'b0, 20000, c);
    rng(w, wlo, whi, "pulse width");
    rng(w + c, plo, phi, "pulse period");
  endtask

  function automatic logic [7:0] ctl(input rtcat_pkg::rtcat_src_e s, input logic r,
                                     input logic t, input logic p);
    return {3'h0, s, r, t, p};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst      = 1'b0;
    time_tick = 1'b0;
    cur_sec   = 7'h00;
    cur_day   = 6'h00;
    cur_wday  = 3'h0;
    addr      = 5'h00;
    wdata     = 8'h00;
    wr_stb    = 1'b0;
    rd_stb    = 1'b0;
    errors    = 0;
    n_tests   = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rdchk(`RTCAT_A_DAY, 8'h80, "day rst");
    rdchk(`RTCAT_A_WDAY, 8'h80, "wday rst");
    rdchk(`RTCAT_A_VAL, 8'h00, "val rst");
    rdchk(`RTCAT_A_CTRL, 8'h18, "ctrl rst");
    rdchk(`RTCAT_A_FLAGS, 8'h00, "flags rst");
    rdchk(5'h1F, 8'h00, "unmapped");
    chk({7'h00, irq_n}, 8'h01, "irq rst");
    wr(`RTCAT_A_DAY, 8'hFF);
    rdchk(`RTCAT_A_DAY, 8'hBF, "day mask");
    wr(`RTCAT_A_WDAY, 8'hFF);
    rdchk(`RTCAT_A_WDAY, 8'h87, "wday mask");
    wr(`RTCAT_A_CTRL, 8'hFF);
    rdchk(`RTCAT_A_CTRL, 8'h1F, "ctrl mask");
    wr(`RTCAT_A_CTRL, 8'h18);
    // Alarm: day enabled, weekday off so its value must not matter
    wr(`RTCAT_A_DAY, 8'h15);
    wr(`RTCAT_A_WDAY, 8'h83);
    wr(`RTCAT_A_FLAGS, 8'h80);
    tick(6'h14, 3'h0);
    rdchk(`RTCAT_A_FLAGS, 8'h80, "no match");
    tick(6'h15, 3'h5);
    chk({7'h00, irq_n}, 8'h00, "alarm irq");
    rdchk(`RTCAT_A_FLAGS, 8'hC0, "alarm set");
    wr(`RTCAT_A_FLAGS, 8'h80);
    chk({7'h00, irq_n}, 8'h01, "alarm irq clr");
    tick(6'h15, 3'h5);
    rdchk(`RTCAT_A_FLAGS, 8'h80, "no reset on hold");
    tick(6'h16, 3'h5);
    tick(6'h15, 3'h5);
    rdchk(`RTCAT_A_FLAGS, 8'hC0, "match again");
    wr(`RTCAT_A_FLAGS, 8'h80);
    wr(`RTCAT_A_WDAY, 8'h03);
    tick(6'h15, 3'h5);
    rdchk(`RTCAT_A_FLAGS, 8'h80, "wday differs");
    tick(6'h15, 3'h3);
    rdchk(`RTCAT_A_FLAGS, 8'hC0, "both match");
    wr(`RTCAT_A_FLAGS, 8'h00);
    tick(6'h16, 3'h3);
    tick(6'h15, 3'h3);
    chk({7'h00, irq_n}, 8'h01, "aie off");
    rdchk(`RTCAT_A_FLAGS, 8'h40, "flag no aie");
    wr(`RTCAT_A_SEC, 8'h30);
    wr(`RTCAT_A_FLAGS, 8'h00);
    tick(6'h15, 3'h3);
    rdchk(`RTCAT_A_FLAGS, 8'h00, "sec differs");
    @(posedge clk);
    cur_sec <= 7'h30;
    tick(6'h15, 3'h3);
    rdchk(`RTCAT_A_FLAGS, 8'h40, "sec match");
    wr(`RTCAT_A_DAY, 8'h80);
    wr(`RTCAT_A_WDAY, 8'h80);
    wr(`RTCAT_A_FLAGS, 8'h00);
    // Timer, 4096 Hz level mode, reload 2
    wr(`RTCAT_A_VAL, 8'h02);
    rdchk(`RTCAT_A_VAL, 8'h02, "val load");
    wr(`RTCAT_A_CTRL, ctl(rtcat_pkg::RTCAT_SRC_4K, 1'b1, 1'b1, 1'b0));
    wait_irq(1'b0, 400, n);
    rng(n, 128, 200, "first period");
    rdchk(`RTCAT_A_FLAGS, 8'h08, "done set");
    sync_cnt(8'h01);
    sync_cnt(8'h02);
    wr(`RTCAT_A_FLAGS, 8'h00);
    chk({7'h00, irq_n}, 8'h01, "level clr");
    wait_irq(1'b0, 200, n);
    rng(n, 100, 130, "next period");
    wr(`RTCAT_A_CTRL, ctl(rtcat_pkg::RTCAT_SRC_4K, 1'b1, 1'b0, 1'b0));
    wr(`RTCAT_A_FLAGS, 8'h00);
    hold(300, "tie off");
    rdchk(`RTCAT_A_FLAGS, 8'h08, "done no tie");
    wr(`RTCAT_A_FLAGS, 8'h00);
    wr(`RTCAT_A_CTRL, ctl(rtcat_pkg::RTCAT_SRC_4K, 1'b1, 1'b1, 1'b1));
    pulse(127, 129, 32, 65);
    wr(`RTCAT_A_VAL, 8'h01);
    pulse(63, 65, 1, 33);
    wr(`RTCAT_A_CTRL, ctl(rtcat_pkg::RTCAT_SRC_64, 1'b1, 1'b1, 1'b1));
    pulse(4095, 4097, 2016, 2049);
    wr(`RTCAT_A_VAL, 8'h02);
    pulse(8191, 8193, 4064, 4097);
    wait_irq(1'b1, 5000, n);
    wr(`RTCAT_A_VAL, 8'h00);
    wr(`RTCAT_A_FLAGS, 8'h00);
    hold(9000, "zero stops");
    rdchk(`RTCAT_A_VAL, 8'h00, "zero count");
    wr(`RTCAT_A_CTRL, ctl(rtcat_pkg::RTCAT_SRC_4K, 1'b0, 1'b1, 1'b0));
    wr(`RTCAT_A_VAL, 8'h05);
    repeat (300) @(posedge clk);
    rdchk(`RTCAT_A_VAL, 8'h05, "frozen");
    // 1 Hz source: no period can end within this short window
    wr(`RTCAT_A_CTRL, ctl(rtcat_pkg::RTCAT_SRC_1, 1'b1, 1'b1, 1'b0));
    hold(3000, "slow src");
    wr(`RTCAT_A_CTRL, 8'h18);
    rdchk(`RTCAT_A_CTRL, 8'h18, "parked");
    results();
  end
endmodule
